// >>> dv/cse_chk.sv
// Port checker for the signaling enable bank.
`timescale 1ns/1ps
`include "cse_consts.vh"

module cse_chk #(
	parameter NUM_CH = 30
) (
	input wire clk_i,
	input wire reset_i,
	input wire [8:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	input wire [7:0] rdata_o,
	input wire tx_hw_valid_i,
	input wire [4:0] tx_hw_slot_i,
	input wire [3:0] tx_hw_abcd_i,
	input wire rx_line_valid_i,
	input wire [4:0] rx_line_slot_i,
	input wire [3:0] rx_line_abcd_i,
	input wire [4:0] tx_line_slot_i,
	input wire [3:0] tx_line_abcd_o,
	input wire [4:0] rx_hw_slot_i,
	input wire [3:0] rx_hw_abcd_o,
	input wire [29:0] sig_enable_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Slot to channel index; slot sixteen carries no channel.
	function automatic logic [4:0] chx(input logic [4:0] s);
		chx = (s < 5'h10) ? s - 5'h01 : s - 5'h02;
	endfunction
	// An enabled update followed at once by a quiet lookup of the same slot.
	sequence tx_upd;
		tx_hw_valid_i && tx_hw_slot_i != 5'h00 && tx_hw_slot_i != 5'h10 && !wr_i &&
			sig_enable_o[chx(tx_hw_slot_i)] ##1
			tx_line_slot_i == $past(tx_hw_slot_i) && !tx_hw_valid_i && !rd_i && !wr_i;
	endsequence
	sequence rx_upd;
		rx_line_valid_i && rx_line_slot_i != 5'h00 && rx_line_slot_i != 5'h10 && !wr_i &&
			sig_enable_o[chx(rx_line_slot_i)] ##1
			rx_hw_slot_i == $past(rx_line_slot_i) && !rx_line_valid_i && !rd_i && !wr_i;
	endsequence
	rd_idle_a: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
	en_low_a: assert property (wr_i && addr_i == `CSE_OFS_EN_LOW |=>
		sig_enable_o[7:0] == $past(wdata_i)) else $error("low group write lost");
	en_second_a: assert property (wr_i && addr_i == `CSE_OFS_EN_SECOND |=>
		sig_enable_o[15:8] == $past(wdata_i)) else $error("second group write lost");
	en_third_a: assert property (wr_i && addr_i == `CSE_OFS_EN_THIRD |=>
		sig_enable_o[23:16] == $past(wdata_i)) else $error("third group write lost");
	en_top_a: assert property (wr_i && addr_i == `CSE_OFS_EN_TOP |=>
		sig_enable_o[29:24] == $past(wdata_i[5:0])) else $error("top group write lost");
	rd_low_a: assert property (rd_i && addr_i == `CSE_OFS_EN_LOW |=>
		rdata_o == $past(sig_enable_o[7:0])) else $error("low group read wrong");
	rd_top_a: assert property (rd_i && addr_i == `CSE_OFS_EN_TOP |=>
		rdata_o == {2'h0, $past(sig_enable_o[29:24])}) else $error("top group read wrong");
	tx_flow_a: assert property (tx_upd |=> tx_line_abcd_o == $past(tx_hw_abcd_i, 2))
		else $error("tx signaling did not flow");
	rx_flow_a: assert property (rx_upd |=> rx_hw_abcd_o == $past(rx_line_abcd_i, 2))
		else $error("rx signaling did not flow");
	cover property (wr_i && addr_i == `CSE_OFS_EN_TOP);
	cover property (tx_upd);
	cover property (rx_upd);
endmodule

bind cse_sig_enable cse_chk #(.NUM_CH(NUM_CH)) cse_chk_inst (.*);

// >>> dv/cse_hw_partner.sv
// Far-side model: highway and line sources of ABCD updates.
`timescale 1ns/1ps

module cse_hw_partner (
	// Clock.
	input wire clk_i,
	// Transmit highway and receive line sources.
	output reg tx_valid_o = 1'h0,
	output reg [4:0] tx_slot_o = 5'h00,
	output reg [3:0] tx_abcd_o = 4'h0,
	output reg rx_valid_o = 1'h0,
	output reg [4:0] rx_slot_o = 5'h00,
	output reg [3:0] rx_abcd_o = 4'h0
);
	// One update per direction; afterwards the data lines show the inverse so a
	// stale value is never mistaken for a live one.
	task send(input logic [4:0] s, input logic [3:0] t, input logic [3:0] r);
		@(posedge clk_i);
		tx_valid_o <= 1'h1;
		tx_slot_o <= s;
		tx_abcd_o <= t;
		rx_valid_o <= 1'h1;
		rx_slot_o <= s;
		rx_abcd_o <= r;
		@(posedge clk_i);
		tx_valid_o <= 1'h0;
		rx_valid_o <= 1'h0;
		tx_abcd_o <= ~t;
		rx_abcd_o <= ~r;
	endtask
endmodule

// >>> dv/cse_sig_enable_bench.sv
// Self-checking bench for the signaling enable bank.
`timescale 1ns/1ps

module cse_sig_enable_bench;
	reg clk_i = 1'h0, reset_i = 1'h1, wr_i = 1'h0, rd_i = 1'h0, lk = 1'h0, rd_s, lk_s;
	reg [8:0] addr_i = 9'h000;
	reg [7:0] wdata_i = 8'h00, v;
	reg [4:0] tx_line_slot_i = 5'h00, rx_hw_slot_i = 5'h00;
	wire [7:0] rdata_o;
	wire [3:0] tx_line_abcd_o, rx_hw_abcd_o, ta, ra;
	wire [4:0] ts, rs;
	wire tv, rv;
	wire [29:0] sig_enable_o;
	logic [7:0] q8[$];
	logic [3:0] qt[$], qr[$], tb[0:31], rb[0:31];
	logic [29:0] en = 30'h3FFFFFFF;
	int errors = 0, n_checks = 0, i;
	int sl[5] = '{1, 15, 17, 31, 9};
	always #2 clk_i = ~clk_i;
	cse_sig_enable #(.NUM_CH(30)) cse_sig_enable_inst (.clk_i(clk_i), .reset_i(reset_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.tx_hw_valid_i(tv), .tx_hw_slot_i(ts), .tx_hw_abcd_i(ta), .rx_line_valid_i(rv),
		.rx_line_slot_i(rs), .rx_line_abcd_i(ra), .tx_line_slot_i(tx_line_slot_i),
		.tx_line_abcd_o(tx_line_abcd_o), .rx_hw_slot_i(rx_hw_slot_i),
		.rx_hw_abcd_o(rx_hw_abcd_o), .sig_enable_o(sig_enable_o));
	cse_hw_partner cse_hw_partner_inst (.clk_i(clk_i), .tx_valid_o(tv), .tx_slot_o(ts),
		.tx_abcd_o(ta), .rx_valid_o(rv), .rx_slot_o(rs), .rx_abcd_o(ra));
	// Compare one result with case equality, so an unknown matches only an unknown.
	task chk(input string n, input logic [29:0] e, input logic [29:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Channel index to slot: slot sixteen is skipped.
	function automatic int slot(input int c);
		slot = (c < 15) ? c + 1 : c + 2;
	endfunction
	task wr(input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wr_i <= 1'h1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'h0;
		if (a >= 9'h1E8 && a <= 9'h1EB) en[(a - 9'h1E8) * 8 +: 8] = d;
		if (a >= 9'h100 && a < 9'h11E) tb[slot(a - 9'h100)] = d[3:0];
		if (a >= 9'h140 && a < 9'h15E) rb[slot(a - 9'h140)] = d[3:0];
	endtask
	task rd(input logic [8:0] a, input logic [7:0] e);
		@(posedge clk_i);
		rd_i <= 1'h1;
		addr_i <= a;
		q8.push_back(e);
		@(posedge clk_i);
		rd_i <= 1'h0;
	endtask
	task look(input logic [4:0] s);
		@(posedge clk_i);
		tx_line_slot_i <= s;
		rx_hw_slot_i <= s;
		lk <= 1'h1;
		qt.push_back(tb[s]);
		qr.push_back(rb[s]);
		@(posedge clk_i);
		lk <= 1'h0;
	endtask
	// Stream update with a lookup right behind it; frozen channels keep their state.
	task upd(input logic [4:0] s);
		v = 8'($urandom);
		if (en[(s < 16) ? s - 1 : s - 2]) begin
			tb[s] = v[3:0];
			rb[s] = v[7:4];
		end
		fork
			cse_hw_partner_inst.send(s, v[3:0], v[7:4]);
			begin
				@(posedge clk_i);
				look(s);
			end
		join
	endtask
	// Result watcher: read data and lookups land one cycle after their request.
	always @(posedge clk_i) begin
		#1;
		if (rd_s === 1'h1) chk("rdata", q8.pop_front(), rdata_o);
		if (lk_s === 1'h1) begin
			chk("tx_abcd", qt.pop_front(), tx_line_abcd_o);
			chk("rx_abcd", qr.pop_front(), rx_hw_abcd_o);
		end
		rd_s = rd_i;
		lk_s = lk;
	end
	initial begin
		#40000;
		errors++;
		end_of_test;
	end
	initial begin
		void'($urandom(40));
		repeat (3) @(posedge clk_i);
		reset_i <= 1'h0;
		for (i = 0; i < 4; i++) rd(9'h1E8 + i, (i == 3) ? 8'h3F : 8'hFF);
		wr(9'h1F0, 8'h5A);
		rd(9'h1F0, 8'h00);
		$display("test reset done");
		repeat (4) for (i = 0; i < 4; i++) begin
			// The host keeps the reserved top bits at zero.
			v = (i == 3) ? 8'($urandom) & 8'h3F : 8'($urandom);
			wr(9'h1E8 + i, v);
			rd(9'h1E8 + i, v);
			chk("enable", en, sig_enable_o);
		end
		for (i = 0; i < 4; i++) wr(9'h1E8 + i, (i == 3) ? 8'h3F : 8'hFF);
		$display("test mapping done");
		for (i = 0; i < 5; i++) upd(sl[i]);
		$display("test flow done");
		wr(9'h1E9, 8'h7F);
		upd(17);
		upd(18);
		wr(9'h10F, 8'h0A);
		wr(9'h14F, 8'h05);
		look(17);
		rd(9'h10F, 8'h0A);
		wr(9'h1E9, 8'hFF);
		look(17);
		upd(17);
		$display("test freeze done");
		end_of_test;
	end
endmodule

// >>> logic/cse_consts.vh
// Constants for the per-channel signaling enable bank and its buffers.
`ifndef CSE_CONSTS_VH
`define CSE_CONSTS_VH

// ************************************************************
// Register map
// ************************************************************
`define CSE_ADDR_W 9
`define CSE_OFS_EN_LOW 9'h1E8
`define CSE_OFS_EN_SECOND 9'h1E9
`define CSE_OFS_EN_THIRD 9'h1EA
`define CSE_OFS_EN_TOP 9'h1EB
// Signaling buffer windows: one ABCD nibble per channel, index = channel - 1.
`define CSE_OFS_TX_SIG_BASE 9'h100
`define CSE_OFS_RX_SIG_BASE 9'h140
`define CSE_SIG_WIN_MASK 9'h1C0
`define CSE_RESET_EN 8'hFF
// Reset value of the six-bit top group: every channel flowing.
`define CSE_RESET_EN_TOP 6'h3F
`define CSE_TOP_VALID_MASK 8'h3F

// ************************************************************
// Channel and slot layout
// ************************************************************
`define CSE_NUM_CH 30
`define CSE_CH_W 5
`define CSE_SIG_SLOT 5'h10
`define CSE_ABCD_W 4

`endif

// >>> logic/cse_sig_enable.v
// Signaling enable bank with frozen-or-flowing ABCD buffers for thirty channels.
`timescale 1ns/1ps
`include "cse_consts.vh"

module cse_sig_enable #(
	parameter NUM_CH = 30
) (
	// Clock and reset.
	input wire clk_i,
	input wire reset_i,
	// Host register port.
	input wire [8:0] addr_i,
	input wire [7:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [7:0] rdata_o,
	// Transmit signaling highway side: slot number and ABCD of that slot.
	input wire tx_hw_valid_i,
	input wire [4:0] tx_hw_slot_i,
	input wire [3:0] tx_hw_abcd_i,
	// Receive line side: ABCD extracted from time slot sixteen.
	input wire rx_line_valid_i,
	input wire [4:0] rx_line_slot_i,
	input wire [3:0] rx_line_abcd_i,
	// Output lookups: slot asked for, ABCD returned one cycle later.
	input wire [4:0] tx_line_slot_i,
	output wire [3:0] tx_line_abcd_o,
	input wire [4:0] rx_hw_slot_i,
	output wire [3:0] rx_hw_abcd_o,
	// Enable vector, channel 1 in bit 0.
	output wire [29:0] sig_enable_o
);

	// ************************************************************
	// Enable registers
	// ************************************************************
	reg [7:0] sig_en_low_group; // Channels 8..1.
	reg [7:0] sig_en_second_group; // Channels 16..9.
	reg [7:0] sig_en_third_group; // Channels 24..17.
	reg [5:0] sig_en_top_group; // Channels 30..25.

	// Full vector of channel_sig_enable_bit values, channel c at bit c-1.
	wire [29:0] channel_sig_enable_bit;
	assign channel_sig_enable_bit = {sig_en_top_group, sig_en_third_group,
		sig_en_second_group, sig_en_low_group};
	assign sig_enable_o = channel_sig_enable_bit;

	// Write decode for the four enable registers.
	// Reset leaves every channel flowing, so signaling passes without setup.
	always @(posedge clk_i) begin
		if (reset_i) begin
			sig_en_low_group <= `CSE_RESET_EN;
			sig_en_second_group <= `CSE_RESET_EN;
			sig_en_third_group <= `CSE_RESET_EN;
			sig_en_top_group <= `CSE_RESET_EN_TOP;
		end else if (wr_i) begin
			case (addr_i)
				`CSE_OFS_EN_LOW: begin
					sig_en_low_group <= wdata_i;
				end
				`CSE_OFS_EN_SECOND: begin
					sig_en_second_group <= wdata_i;
				end
				`CSE_OFS_EN_THIRD: begin
					sig_en_third_group <= wdata_i;
				end
				`CSE_OFS_EN_TOP: begin
					// Reserved bits 7..6 are dropped and read back as zero.
					sig_en_top_group <= wdata_i[5:0];
				end
				default: begin
					sig_en_top_group <= sig_en_top_group;
				end
			endcase
		end
	end

	// ************************************************************
	// Slot to channel translation
	// ************************************************************
	wire [4:0] tx_in_ch;
	wire tx_in_ok;
	wire [4:0] rx_in_ch;
	wire rx_in_ok;
	wire [4:0] tx_out_ch;
	wire tx_out_ok;
	wire [4:0] rx_out_ch;
	wire rx_out_ok;

	cse_slot_map u_map_tx_in (
		.slot_i(tx_hw_slot_i),
		.ch_idx_o(tx_in_ch),
		.valid_o(tx_in_ok)
	);
	cse_slot_map u_map_rx_in (
		.slot_i(rx_line_slot_i),
		.ch_idx_o(rx_in_ch),
		.valid_o(rx_in_ok)
	);
	cse_slot_map u_map_tx_out (
		.slot_i(tx_line_slot_i),
		.ch_idx_o(tx_out_ch),
		.valid_o(tx_out_ok)
	);
	cse_slot_map u_map_rx_out (
		.slot_i(rx_hw_slot_i),
		.ch_idx_o(rx_out_ch),
		.valid_o(rx_out_ok)
	);

	// ************************************************************
	// Host access decode for the signaling buffers
	// ************************************************************
	// Buffer windows: index 0..29 within each 64-byte window.
	wire host_tx_hit;
	wire host_rx_hit;
	wire [4:0] host_ch;
	assign host_ch = addr_i[4:0];
	assign host_tx_hit = ((addr_i & `CSE_SIG_WIN_MASK) == `CSE_OFS_TX_SIG_BASE)
		&& (addr_i[5] == 1'b0) && (host_ch < NUM_CH);
	assign host_rx_hit = ((addr_i & `CSE_SIG_WIN_MASK) == `CSE_OFS_RX_SIG_BASE)
		&& (addr_i[5] == 1'b0) && (host_ch < NUM_CH);

	// ************************************************************
	// Buffer update arbitration
	// ************************************************************
	// A host write always lands; the automatic path only lands while the
	// channel is enabled. The host has priority in the same cycle, which
	// matters only for a flowing channel whose value the next frame replaces.
	reg tx_we;
	reg [4:0] tx_wa;
	reg [3:0] tx_wd;
	reg rx_we;
	reg [4:0] rx_wa;
	reg [3:0] rx_wd;

	always @* begin
		tx_we = 1'b0;
		tx_wa = tx_in_ch;
		tx_wd = tx_hw_abcd_i;
		if (wr_i && host_tx_hit) begin
			// Frozen channels keep this value until rewritten or re-enabled.
			tx_we = 1'b1;
			tx_wa = host_ch;
			tx_wd = wdata_i[3:0];
		end else if (tx_hw_valid_i && tx_in_ok) begin
			// Highway update passes only for enabled channels.
			tx_we = channel_sig_enable_bit[tx_in_ch];
		end
	end

	always @* begin
		rx_we = 1'b0;
		rx_wa = rx_in_ch;
		rx_wd = rx_line_abcd_i;
		if (wr_i && host_rx_hit) begin
			rx_we = 1'b1;
			rx_wa = host_ch;
			rx_wd = wdata_i[3:0];
		end else if (rx_line_valid_i && rx_in_ok) begin
			// Line update from slot sixteen passes only for enabled channels.
			rx_we = channel_sig_enable_bit[rx_in_ch];
		end
	end

	// ************************************************************
	// Read port arbitration
	// ************************************************************
	// Each memory has one read port shared by the outgoing stream and the host.
	// The host read wins; the stream sees the previous cycle's value held.
	wire [4:0] tx_ra;
	wire [4:0] rx_ra;
	wire host_rd_tx;
	wire host_rd_rx;
	assign host_rd_tx = rd_i && host_tx_hit;
	assign host_rd_rx = rd_i && host_rx_hit;
	assign tx_ra = host_rd_tx ? host_ch : tx_out_ch;
	assign rx_ra = host_rd_rx ? host_ch : rx_out_ch;

	wire [3:0] tx_rd;
	wire [3:0] rx_rd;

	cse_sig_mem #(.DEPTH(`CSE_NUM_CH), .AW(`CSE_CH_W), .DW(`CSE_ABCD_W)) u_tx_buf (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_en_i(tx_we),
		.wr_addr_i(tx_wa),
		.wr_data_i(tx_wd),
		.rd_addr_i(tx_ra),
		.rd_data_o(tx_rd)
	);

	cse_sig_mem #(.DEPTH(`CSE_NUM_CH), .AW(`CSE_CH_W), .DW(`CSE_ABCD_W)) u_rx_buf (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.wr_en_i(rx_we),
		.wr_addr_i(rx_wa),
		.wr_data_i(rx_wd),
		.rd_addr_i(rx_ra),
		.rd_data_o(rx_rd)
	);

	// ************************************************************
	// Outgoing streams
	// ************************************************************
	// Track which cycles gave the stream the port and a real channel slot.
	reg tx_out_live;
	reg rx_out_live;
	reg [3:0] tx_out_hold;
	reg [3:0] rx_out_hold;
	reg host_rd_tx_q;
	reg host_rd_rx_q;
	reg [7:0] en_rdata_q;
	reg en_rd_q;

	always @(posedge clk_i) begin
		if (reset_i) begin
			tx_out_live <= 1'b0;
			rx_out_live <= 1'b0;
			tx_out_hold <= 4'h0;
			rx_out_hold <= 4'h0;
		end else begin
			tx_out_live <= tx_out_ok && !host_rd_tx;
			rx_out_live <= rx_out_ok && !host_rd_rx;
			if (tx_out_live) begin
				tx_out_hold <= tx_rd;
			end
			if (rx_out_live) begin
				rx_out_hold <= rx_rd;
			end
		end
	end

	// Buffered values feed the transmit line and receive highway whether
	// flowing or frozen; a frozen channel simply repeats its held state.
	assign tx_line_abcd_o = tx_out_live ? tx_rd : tx_out_hold;
	assign rx_hw_abcd_o = rx_out_live ? rx_rd : rx_out_hold;

	// ************************************************************
	// Host read data
	// ************************************************************
	// Enable registers are captured at the read; buffers arrive from memory.
	always @(posedge clk_i) begin
		if (reset_i) begin
			host_rd_tx_q <= 1'b0;
			host_rd_rx_q <= 1'b0;
			en_rd_q <= 1'b0;
			en_rdata_q <= 8'h00;
		end else begin
			host_rd_tx_q <= host_rd_tx;
			host_rd_rx_q <= host_rd_rx;
			en_rd_q <= rd_i;
			case (addr_i)
				`CSE_OFS_EN_LOW: en_rdata_q <= sig_en_low_group;
				`CSE_OFS_EN_SECOND: en_rdata_q <= sig_en_second_group;
				`CSE_OFS_EN_THIRD: en_rdata_q <= sig_en_third_group;
				`CSE_OFS_EN_TOP: en_rdata_q <= {2'b00, sig_en_top_group};
				default: en_rdata_q <= 8'h00;
			endcase
		end
	end

	// Read data stand only in the cycle after the strobe, zero otherwise.
	always @* begin
		rdata_o = 8'h00;
		if (host_rd_tx_q) begin
			rdata_o = {4'h0, tx_rd};
		end else if (host_rd_rx_q) begin
			rdata_o = {4'h0, rx_rd};
		end else if (en_rd_q) begin
			rdata_o = en_rdata_q;
		end
	end

endmodule

// >>> logic/cse_sig_mem.v
// Small ABCD signaling memory with one update port and registered read.
`timescale 1ns/1ps

module cse_sig_mem #(
	parameter DEPTH = 30,
	parameter AW = 5,
	parameter DW = 4
) (
	// Clock and reset.
	input wire clk_i,
	input wire reset_i,
	// Update port.
	input wire wr_en_i,
	input wire [AW-1:0] wr_addr_i,
	input wire [DW-1:0] wr_data_i,
	// Registered read port.
	input wire [AW-1:0] rd_addr_i,
	output reg [DW-1:0] rd_data_o
);

	// Storage array; contents are not reset, like the real buffer.
	reg [DW-1:0] mem [0:DEPTH-1];

	// ************************************************************
	// Write and registered read
	// ************************************************************
	// Read data lag the address by one cycle so the caller can align it.
	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		if (reset_i) begin
			rd_data_o <= {DW{1'b0}};
		end else begin
			rd_data_o <= mem[rd_addr_i];
		end
	end

endmodule

// >>> logic/cse_slot_map.v
// Maps a time slot number to its telephone channel index.
`timescale 1ns/1ps
`include "cse_consts.vh"

module cse_slot_map (
	// Time slot number of the current signaling position.
	input wire [4:0] slot_i,
	// Zero-based channel index and whether the slot carries a channel.
	output reg [4:0] ch_idx_o,
	output reg valid_o
);

	// ************************************************************
	// Slot to channel mapping
	// ************************************************************
	// Slot 0 carries framing and slot sixteen signaling, so neither is a channel.
	always @* begin
		ch_idx_o = 5'h00;
		valid_o = 1'b0;
		if (slot_i == 5'h00 || slot_i == `CSE_SIG_SLOT) begin
			valid_o = 1'b0;
		end else if (slot_i < `CSE_SIG_SLOT) begin
			// Channels 1 to 15 sit in slots of the same number.
			ch_idx_o = slot_i - 5'h01;
			valid_o = 1'b1;
		end else begin
			// Channels 16 to 30 sit one slot higher.
			ch_idx_o = slot_i - 5'h02;
			valid_o = 1'b1;
		end
	end

endmodule
